// File: fosc_pkg.sv
// constants, codes and types for the fan override and spin-up control
// assumes a 100 MHz mclk and 8-bit whole-degree temperature codes
package fosc_pkg;
   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [7:0] ADDR_STATUS1 = 8'h02;
   localparam logic [7:0] ADDR_STATUS2 = 8'h03;
   localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h04;
   localparam logic [7:0] ADDR_FAN_TRAITS = 8'h20;
   localparam logic [7:0] CONFIG_FOUR_RESET = 8'h00;
   localparam logic [7:0] FAN_TRAITS_RESET = 8'h05;
   localparam int CFG4_TACH_FAST_BIT = 5;
   localparam int FT_SPINUP_DIS_BIT = 5;
   localparam int FT_TIME_MSB = 2;
   localparam int FT_TIME_LSB = 0;
   localparam int ST1_FANS_BIT = 1;
   localparam int ST1_REMOTE_OT_BIT = 6;
   localparam int ST2_LOCAL_OT_BIT = 6;
   localparam int ST2_EXT_REQ_BIT = 3;
   // ***************************************************
   // duty codes, 8'hff is full duty
   // ***************************************************
   localparam logic [7:0] DUTY_FULL = 8'hff;
   localparam logic [7:0] DUTY_ZERO = 8'h00;
   localparam logic [7:0] DUTY_SPIN = 8'h55;
   localparam logic [16:0] SPIN_RAMP_INC = 17'h001fe;
   localparam logic [7:0] DUTY_MIN_DIRECT = 8'h12;
   localparam logic [7:0] DUTY_MIN_REG = 8'h4d;
   localparam logic [15:0] REG_DEADBAND = 16'h000a;
   localparam logic [8:0] HYST_DEGC = 9'h005;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 100000;
   localparam int TICK_CYCLES_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICKS_PER_MS = 1000000 / TICK_NS;
   localparam int REG_PERIOD_MS = 1000;
   localparam int REG_FAST_MS = 250;
   localparam logic [13:0] REG_TICKS = 14'(REG_PERIOD_MS * TICKS_PER_MS);
   localparam logic [13:0] REG_FAST_TICKS = 14'(REG_FAST_MS * TICKS_PER_MS);
   localparam int SPIN_MS_0 = 200;
   localparam int SPIN_MS_1 = 400;
   localparam int SPIN_MS_2 = 600;
   localparam int SPIN_MS_3 = 800;
   localparam int SPIN_MS_4 = 1000;
   localparam int SPIN_MS_5 = 2000;
   localparam int SPIN_MS_6 = 4000;
   localparam int SPIN_MS_7 = 8000;

   typedef enum logic [1:0] {
      FOSC_MODE_DIRECT = 2'b00,
      FOSC_MODE_REGULATE = 2'b01,
      FOSC_MODE_AUTO_REMOTE = 2'b10,
      FOSC_MODE_AUTO_MAX = 2'b11
   } fosc_mode_type;

   typedef enum logic [1:0] {
      FOSC_SPIN_IDLE = 2'b00,
      FOSC_SPIN_RAMP = 2'b01,
      FOSC_SPIN_HOLD = 2'b10,
      FOSC_SPIN_FINISH = 2'b11
   } fosc_spin_type;

   // spin-up length in ticks for the time select code
   function automatic logic [16:0] spin_ticks(input logic [2:0] sel);
      logic [16:0] t;
      t = 17'(SPIN_MS_5 * TICKS_PER_MS);
      case (sel)
         3'h0: t = 17'(SPIN_MS_0 * TICKS_PER_MS);
         3'h1: t = 17'(SPIN_MS_1 * TICKS_PER_MS);
         3'h2: t = 17'(SPIN_MS_2 * TICKS_PER_MS);
         3'h3: t = 17'(SPIN_MS_3 * TICKS_PER_MS);
         3'h4: t = 17'(SPIN_MS_4 * TICKS_PER_MS);
         3'h5: t = 17'(SPIN_MS_5 * TICKS_PER_MS);
         3'h6: t = 17'(SPIN_MS_6 * TICKS_PER_MS);
         default: t = 17'(SPIN_MS_7 * TICKS_PER_MS);
      endcase
      return t;
   endfunction
endpackage

// File: fosc_core.sv
// fan duty control: over-temperature pin, override, spin-up, sw modes
// assumes temperatures, limits and tach results come from logic on mclk;
// the over-temperature pin is open drain and is resolved outside
//
// Notes on behaviour
// - pin low above a limit until temperature is 5 degrees below it
// - crossing sets the channel flag; alert pulled only with enable set
// - either flag set forces the pin low whatever the enable
// - status read clears flags and alert, pin stays low in hysteresis
// - a cleared flag re-arms only after falling 5 degrees below limit
// - override enable with pin low gives full duty, else only outside requests count
// - external low on the pin sets request bit and forces full duty
// - spin-up ramps third to full, holds full, ends at a third
// - three-bit select picks spin-up time, 2 s after reset
// - spin-up disable bit suppresses spin-up, clear after reset
// - a speed measurement starts right when spin-up ends
// - no fan-slow check during spin-up; flag cleared only by read
// - after spin-up fan-slow stays set until it is read
// - mode 00 is direct duty, 01 is the speed regulator
// - direct mode applies a written setpoint at once
// - direct mode forces zero under 7% when tach on and mode bit low
// - direct mode keeps low setpoints when tach off or mode bit high
// - regulator works only with tach on, steering period to target
// - regulator steps once per second or per 250 ms, step limited
// - regulator stops adjusting within 0x000a of target
// - regulator output floored at 30% when tach mode bit low
// - tach mode low holds the output on during tach edges
`timescale 1ns/10ps
module fosc_core #(
   parameter int TICK_CYCLES = fosc_pkg::TICK_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] remote_temp,
   input wire logic [7:0] local_temp,
   input wire logic [7:0] remote_therm_limit,
   input wire logic [7:0] local_therm_limit,
   input wire logic overtemp_irq_enable,
   input wire logic fan_override_enable,
   input wire logic therm_in,
   output logic therm_out,
   output logic therm_oe_n,
   output logic alert_oe_n,
   input wire logic tach_en,
   input wire logic tach_mode,
   input wire logic [1:0] fan_mode_sel,
   input wire logic [7:0] duty_setpoint,
   input wire logic [1:0] ramp_step_size,
   input wire logic [7:0] auto_duty,
   input wire logic [15:0] tach_data,
   input wire logic [15:0] tach_target,
   input wire logic [15:0] tach_low_limit,
   input wire logic meas_done,
   input wire logic tach_hold,
   output logic pwm_out,
   output logic [7:0] duty_now,
   output logic meas_start,
   output logic spinning
);
   typedef struct packed {
      logic [7:0] config_four;
      logic [7:0] fan_traits;
      logic [7:0] rdata;
      logic [1:0] therm_sync;
      logic [1:0] drive_hist;
      logic trip_r;
      logic trip_l;
      logic armed_r;
      logic armed_l;
      logic flag_r;
      logic flag_l;
      logic flag_ext;
      logic flag_fans;
      logic alert_oe_n;
      logic therm_oe_n;
      logic [13:0] tick_cnt;
      logic tick;
      fosc_pkg::fosc_spin_type spin;
      logic start_pend;
      logic [16:0] spin_cnt;
      logic [16:0] spin_acc;
      logic [7:0] spin_duty;
      logic [13:0] reg_cnt;
      logic [7:0] reg_duty;
      logic [7:0] duty;
      logic [7:0] pwm_cnt;
      logic pwm;
      logic meas_start;
      logic spinning;
   } fosc_state_type;

   fosc_state_type st;
   fosc_state_type next_st;
   logic override;
   logic rd_st1;
   logic rd_st2;
   logic rel_r;
   logic rel_l;
   logic [16:0] spin_len;
   logic [7:0] mode_duty;
   logic [8:0] step;
   logic [8:0] sum;
   logic [15:0] diff;
   logic slow_now;

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      next_st = st;
      next_st.meas_start = 1'b0;
      rd_st1 = reg_rd && (reg_addr == fosc_pkg::ADDR_STATUS1);
      rd_st2 = reg_rd && (reg_addr == fosc_pkg::ADDR_STATUS2);
      // register port
      if (reg_wr && reg_addr == fosc_pkg::ADDR_CONFIG_FOUR) begin
         next_st.config_four = reg_wdata;
      end
      if (reg_wr && reg_addr == fosc_pkg::ADDR_FAN_TRAITS) begin
         next_st.fan_traits = reg_wdata;
      end
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            fosc_pkg::ADDR_CONFIG_FOUR: next_st.rdata = st.config_four;
            fosc_pkg::ADDR_FAN_TRAITS: next_st.rdata = st.fan_traits;
            fosc_pkg::ADDR_STATUS1: begin
               next_st.rdata[fosc_pkg::ST1_FANS_BIT] = st.flag_fans;
               next_st.rdata[fosc_pkg::ST1_REMOTE_OT_BIT] = st.flag_r;
            end
            fosc_pkg::ADDR_STATUS2: begin
               next_st.rdata[fosc_pkg::ST2_LOCAL_OT_BIT] = st.flag_l;
               next_st.rdata[fosc_pkg::ST2_EXT_REQ_BIT] = st.flag_ext;
            end
            default: next_st.rdata = 8'h00;
         endcase
      end
      rel_r = ({1'b0, remote_temp} + fosc_pkg::HYST_DEGC)
         <= {1'b0, remote_therm_limit};
      rel_l = ({1'b0, local_temp} + fosc_pkg::HYST_DEGC)
         <= {1'b0, local_therm_limit};
      if (remote_temp > remote_therm_limit) begin
         next_st.trip_r = 1'b1;
      end else if (rel_r) begin
         next_st.trip_r = 1'b0;
      end
      if (local_temp > local_therm_limit) begin
         next_st.trip_l = 1'b1;
      end else if (rel_l) begin
         next_st.trip_l = 1'b0;
      end
      // sticky flags, set beats read clear
      next_st.flag_r = (st.flag_r && !rd_st1)
         || (remote_temp > remote_therm_limit && st.armed_r);
      next_st.flag_l = (st.flag_l && !rd_st2)
         || (local_temp > local_therm_limit && st.armed_l);
      if (remote_temp > remote_therm_limit && st.armed_r) begin
         next_st.armed_r = 1'b0;
      end else if (rel_r) begin
         next_st.armed_r = 1'b1;
      end
      if (local_temp > local_therm_limit && st.armed_l) begin
         next_st.armed_l = 1'b0;
      end else if (rel_l) begin
         next_st.armed_l = 1'b1;
      end
      // pin driven by trips or flags
      next_st.therm_oe_n = !(next_st.trip_r || next_st.trip_l
         || next_st.flag_r || next_st.flag_l);
      next_st.alert_oe_n = !(overtemp_irq_enable
         && (next_st.flag_r || next_st.flag_l));
      // low pin while released for three cycles is an outside request
      next_st.therm_sync = {st.therm_sync[0], therm_in};
      next_st.drive_hist = {st.drive_hist[0], st.therm_oe_n};
      next_st.flag_ext = !st.therm_sync[1] && (st.drive_hist == 2'b11)
         && st.therm_oe_n;
      override = st.flag_ext || (fan_override_enable && !st.therm_oe_n);
      // time base
      next_st.tick = (st.tick_cnt == 14'(TICK_CYCLES - 1));
      next_st.tick_cnt = next_st.tick ? 14'h0000 : st.tick_cnt + 14'h0001;
      slow_now = meas_done && (st.spin == fosc_pkg::FOSC_SPIN_IDLE)
         && (tach_data > tach_low_limit);
      next_st.flag_fans = (st.flag_fans && !rd_st1) || slow_now;
      if (slow_now) begin
         next_st.start_pend = 1'b1;
      end
      spin_len = fosc_pkg::spin_ticks(st.fan_traits[fosc_pkg::FT_TIME_MSB:
         fosc_pkg::FT_TIME_LSB]);
      case (st.spin)
         fosc_pkg::FOSC_SPIN_IDLE: begin
            if (st.start_pend) begin
               next_st.start_pend = 1'b0;
               if (!st.fan_traits[fosc_pkg::FT_SPINUP_DIS_BIT]) begin
                  next_st.spin = fosc_pkg::FOSC_SPIN_RAMP;
                  next_st.spin_cnt = 17'h00000;
                  next_st.spin_acc = 17'h00000;
                  next_st.spin_duty = fosc_pkg::DUTY_SPIN;
               end
            end
         end
         fosc_pkg::FOSC_SPIN_RAMP: begin
            if (st.tick) begin
               next_st.spin_cnt = st.spin_cnt + 17'h00001;
               if (st.spin_acc + fosc_pkg::SPIN_RAMP_INC >= spin_len) begin
                  next_st.spin_acc = st.spin_acc + fosc_pkg::SPIN_RAMP_INC
                     - spin_len;
                  if (st.spin_duty != fosc_pkg::DUTY_FULL) begin
                     next_st.spin_duty = st.spin_duty + 8'h01;
                  end
               end else begin
                  next_st.spin_acc = st.spin_acc + fosc_pkg::SPIN_RAMP_INC;
               end
               if ({2'b00, next_st.spin_cnt} * 19'h00003 >= {2'b00, spin_len})
                  begin
                  next_st.spin = fosc_pkg::FOSC_SPIN_HOLD;
                  next_st.spin_duty = fosc_pkg::DUTY_FULL;
               end
            end
         end
         fosc_pkg::FOSC_SPIN_HOLD: begin
            if (st.tick) begin
               next_st.spin_cnt = st.spin_cnt + 17'h00001;
               if (next_st.spin_cnt >= spin_len) begin
                  next_st.spin = fosc_pkg::FOSC_SPIN_FINISH;
               end
            end
         end
         fosc_pkg::FOSC_SPIN_FINISH: begin
            next_st.spin = fosc_pkg::FOSC_SPIN_IDLE;
            next_st.spin_duty = fosc_pkg::DUTY_SPIN;
            next_st.meas_start = 1'b1;
            next_st.flag_fans = 1'b1;
            next_st.reg_duty = fosc_pkg::DUTY_SPIN;
         end
         default: next_st.spin = fosc_pkg::FOSC_SPIN_IDLE;
      endcase
      next_st.spinning = (next_st.spin != fosc_pkg::FOSC_SPIN_IDLE);
      step = {7'h00, ramp_step_size} + 9'h001;
      diff = (tach_data > tach_target) ? tach_data - tach_target
         : tach_target - tach_data;
      sum = 9'h000;
      if (st.tick) begin
         if (st.reg_cnt >= ((st.config_four[fosc_pkg::CFG4_TACH_FAST_BIT])
            ? fosc_pkg::REG_FAST_TICKS : fosc_pkg::REG_TICKS) - 14'h0001)
            begin
            next_st.reg_cnt = 14'h0000;
            if (fan_mode_sel == fosc_pkg::FOSC_MODE_REGULATE && tach_en
               && st.spin == fosc_pkg::FOSC_SPIN_IDLE
               && diff > fosc_pkg::REG_DEADBAND) begin
               if (tach_data > tach_target) begin
                  sum = {1'b0, st.reg_duty} + step;
                  next_st.reg_duty = sum[8] ? fosc_pkg::DUTY_FULL : sum[7:0];
               end else begin
                  sum = {1'b0, st.reg_duty} - step;
                  next_st.reg_duty = sum[8] ? fosc_pkg::DUTY_ZERO : sum[7:0];
               end
            end
         end else begin
            next_st.reg_cnt = st.reg_cnt + 14'h0001;
         end
      end
      case (fan_mode_sel)
         fosc_pkg::FOSC_MODE_DIRECT: begin
            mode_duty = duty_setpoint;
            if (tach_en && !tach_mode
               && duty_setpoint < fosc_pkg::DUTY_MIN_DIRECT) begin
               mode_duty = fosc_pkg::DUTY_ZERO;
            end
         end
         fosc_pkg::FOSC_MODE_REGULATE: begin
            mode_duty = st.reg_duty;
            if (!tach_mode && st.reg_duty < fosc_pkg::DUTY_MIN_REG) begin
               mode_duty = fosc_pkg::DUTY_MIN_REG;
            end
         end
         default: mode_duty = auto_duty;
      endcase
      // override first, then spin-up, then mode
      if (override) begin
         next_st.duty = fosc_pkg::DUTY_FULL;
      end else if (st.spin != fosc_pkg::FOSC_SPIN_IDLE) begin
         next_st.duty = (st.spin == fosc_pkg::FOSC_SPIN_FINISH)
            ? fosc_pkg::DUTY_SPIN : st.spin_duty;
      end else begin
         next_st.duty = mode_duty;
      end
      // pwm compare, full code always on
      next_st.pwm_cnt = st.pwm_cnt + 8'h01;
      next_st.pwm = (st.duty == fosc_pkg::DUTY_FULL)
         || (st.pwm_cnt < st.duty) || (tach_hold && !tach_mode);
   end

   // ***************************************************
   // state register
   // ***************************************************
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st <= '0;
         st.config_four <= fosc_pkg::CONFIG_FOUR_RESET;
         st.fan_traits <= fosc_pkg::FAN_TRAITS_RESET;
         st.therm_sync <= 2'b11;
         st.drive_hist <= 2'b11;
         st.armed_r <= 1'b1;
         st.armed_l <= 1'b1;
         st.alert_oe_n <= 1'b1;
         st.therm_oe_n <= 1'b1;
         st.spin <= fosc_pkg::FOSC_SPIN_IDLE;
         st.start_pend <= 1'b1;
         st.spin_duty <= fosc_pkg::DUTY_SPIN;
         st.reg_duty <= fosc_pkg::DUTY_SPIN;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   // the pin is only ever pulled low; the enable carries the level
   assign therm_out = 1'b0;
   assign therm_oe_n = st.therm_oe_n;
   assign alert_oe_n = st.alert_oe_n;
   assign pwm_out = st.pwm;
   assign duty_now = st.duty;
   assign meas_start = st.meas_start;
   assign spinning = st.spinning;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   chk_pin_over_limit: assert property (
      remote_temp > remote_therm_limit |=> !therm_oe_n)
      else $error("pin not low above remote limit");
   chk_alert_gate_off: assert property (
      !overtemp_irq_enable |=> alert_oe_n)
      else $error("alert pulled with enable clear");
   chk_flag_forces_pin: assert property (
      (st.flag_r || st.flag_l) |-> !therm_oe_n)
      else $error("flag set but pin released");
   chk_read_keeps_pin: assert property (
      rd_st1 && st.trip_r && !rel_r && !st.armed_r
      |=> !st.flag_r && !therm_oe_n)
      else $error("status read mishandled flag or pin");
   chk_flag_rearm: assert property (
      $rose(st.flag_r) |-> $past(st.armed_r))
      else $error("flag set again before re-arm");
   chk_override_full: assert property (
      override |=> duty_now == fosc_pkg::DUTY_FULL)
      else $error("override did not give full duty");
   chk_ext_req_full: assert property (
      st.flag_ext |=> duty_now == fosc_pkg::DUTY_FULL)
      else $error("outside request not at full duty");
   chk_spin_end_duty: assert property (
      st.spin == fosc_pkg::FOSC_SPIN_FINISH && !override
      |=> duty_now == fosc_pkg::DUTY_SPIN && meas_start && st.flag_fans)
      else $error("spin-up end wrong");
   chk_spin_disabled: assert property (
      st.fan_traits[fosc_pkg::FT_SPINUP_DIS_BIT]
      && st.spin == fosc_pkg::FOSC_SPIN_IDLE |=> !spinning)
      else $error("spin-up ran while disabled");
   chk_direct_low_cut: assert property (
      fan_mode_sel == fosc_pkg::FOSC_MODE_DIRECT && !override && !spinning
      && tach_en && !tach_mode && duty_setpoint < fosc_pkg::DUTY_MIN_DIRECT
      |=> duty_now == fosc_pkg::DUTY_ZERO)
      else $error("low setpoint not cut");
   chk_reg_floor: assert property (
      fan_mode_sel == fosc_pkg::FOSC_MODE_REGULATE && !override
      && !spinning && !tach_mode |=> duty_now >= fosc_pkg::DUTY_MIN_REG)
      else $error("regulator below floor");

   cov_spin_done: cover property (st.spin == fosc_pkg::FOSC_SPIN_FINISH);
   cov_ext_req: cover property ($rose(st.flag_ext));
   cov_flag_read: cover property (st.flag_r ##1 rd_st1 ##1 !st.flag_r);
endmodule

// File: fosc_fan_model.sv
// fan partner: tach results, measurement window, open-drain pin level
// assumes mclk at 100 MHz; the bench sets the fan period and external pull
`timescale 1ns/10ps
module fosc_fan_model #(
   parameter int MEAS_GAP = 500
) (
   input wire logic mclk,
   input wire logic therm_oe_n,
   input wire logic ext_pull,
   input wire logic [15:0] period,
   output logic [15:0] tach_data,
   output logic meas_done,
   output logic tach_hold,
   output logic therm_in
);
   int cnt = 0;
   initial tach_data = 16'h0000;
   initial meas_done = 1'b0;
   initial tach_hold = 1'b0;
   // external pin pull
   // pull-up on the pin: low when either party pulls it
   assign therm_in = therm_oe_n & ~ext_pull;
   always @(posedge mclk) begin
      cnt <= (cnt == MEAS_GAP - 1) ? 0 : cnt + 1;
      meas_done <= (cnt == MEAS_GAP - 1);
      tach_hold <= (cnt > MEAS_GAP - 20);
      if (cnt == MEAS_GAP - 1) begin
         tach_data <= period;
      end
   end
endmodule

// File: fan_override_spinup_control_tb.sv
// self-checking bench for fosc_core with a fan partner model
// assumes TICK_CYCLES of 2, so one second is 20000 mclk cycles
`timescale 1ns/10ps
module fan_override_spinup_control_tb;
   logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [7:0] remote_temp = 8'h20, local_temp = 8'h20;
   logic [7:0] remote_therm_limit = 8'h50, local_therm_limit = 8'h60;
   logic overtemp_irq_enable = 1'b1, fan_override_enable = 1'b1;
   logic therm_in, therm_out, therm_oe_n, alert_oe_n, ext_pull = 1'b0;
   logic tach_en = 1'b1, tach_mode = 1'b0;
   logic [1:0] fan_mode_sel = 2'b00, ramp_step_size = 2'b01;
   logic [7:0] duty_setpoint = 8'h80, auto_duty = 8'h40, duty_now, d0;
   logic [15:0] tach_data, period = 16'h1000;
   logic [15:0] tach_target = 16'h1000, tach_low_limit = 16'h8000;
   logic meas_done, tach_hold, pwm_out, meas_start, spinning;
   logic [7:0] d;
   logic [25:0] tbl [5] = '{26'h2011100, 26'h2012112, 26'h3011111,
      26'h0011111, 26'h2080180};
   int n_errors = 0, cmp_count = 0, n = 0;
   always #5 mclk = ~mclk;
   fosc_core #(.TICK_CYCLES(2)) dut_u (.mclk, .reset, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .remote_temp, .local_temp,
      .remote_therm_limit, .local_therm_limit, .overtemp_irq_enable,
      .fan_override_enable, .therm_in, .therm_out, .therm_oe_n,
      .alert_oe_n, .tach_en, .tach_mode, .fan_mode_sel, .duty_setpoint,
      .ramp_step_size, .auto_duty, .tach_data, .tach_target,
      .tach_low_limit, .meas_done, .tach_hold, .pwm_out, .duty_now,
      .meas_start, .spinning);
   fosc_fan_model fan_u (.mclk, .therm_oe_n, .ext_pull, .period,
      .tach_data, .meas_done, .tach_hold, .therm_in);
   // ***************************************************
   // access and compare tasks
   // ***************************************************
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      cyc(1);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      cyc(1);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      cyc(1);
      reg_rd = 1'b1;
      reg_addr = a;
      cyc(1);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic wait_spin(input logic v, input int lim);
      n = 0;
      while (spinning !== v && n < lim) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic conclude();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   initial begin
      cyc(8);
      reset = 1'b0;
      cyc(1);
      chk(spinning, 1'b1);
      rd(fosc_pkg::ADDR_FAN_TRAITS);
      chk(d, fosc_pkg::FAN_TRAITS_RESET);
      rd(fosc_pkg::ADDR_CONFIG_FOUR);
      chk(d, fosc_pkg::CONFIG_FOUR_RESET);
      rd(8'h7f);
      chk(d, 8'h00);
      cyc(3000);
      chk(duty_now > 8'h55 && duty_now < 8'hff, 1'b1);
      cyc(17000);
      chk(duty_now, fosc_pkg::DUTY_FULL);
      n = 0;
      while (meas_start !== 1'b1 && n < 25000) begin
         cyc(1);
         n++;
      end
      chk(meas_start, 1'b1);
      rd(fosc_pkg::ADDR_STATUS1);
      chk(d[1], 1'b1);
      rd(fosc_pkg::ADDR_STATUS1);
      chk(d[1], 1'b0);
      foreach (tbl[i]) begin
         tach_mode = tbl[i][24];
         tach_en = tbl[i][25];
         duty_setpoint = tbl[i][19:12];
         cyc(2);
         chk(duty_now, tbl[i][7:0]);
      end
      duty_setpoint = 8'h00;
      cyc(2);
      for (n = 0; n < 600 && tach_hold !== 1'b1; n++) cyc(1);
      cyc(1);
      chk(pwm_out, 1'b1);
      tach_mode = 1'b1;
      cyc(2);
      chk(pwm_out, 1'b0);
      tach_mode = 1'b0;
      duty_setpoint = 8'h80;
      cyc(2);
      remote_temp = 8'h51;
      cyc(3);
      chk(therm_oe_n, 1'b0);
      chk(alert_oe_n, 1'b0);
      chk(duty_now, fosc_pkg::DUTY_FULL);
      rd(fosc_pkg::ADDR_STATUS1);
      chk(d[6], 1'b1);
      cyc(1);
      chk({alert_oe_n, therm_oe_n}, 2'b10);
      rd(fosc_pkg::ADDR_STATUS1);
      chk(d[6], 1'b0);
      remote_temp = 8'h4c;
      cyc(3);
      chk(therm_oe_n, 1'b0);
      remote_temp = 8'h4b;
      cyc(4);
      chk({therm_oe_n, duty_now}, 9'h180);
      {overtemp_irq_enable, fan_override_enable} = 2'b00;
      local_temp = 8'h61;
      cyc(3);
      chk({therm_oe_n, alert_oe_n, duty_now}, 10'h180);
      rd(fosc_pkg::ADDR_STATUS2);
      chk(d[6], 1'b1);
      local_temp = 8'h20;
      ext_pull = 1'b1;
      cyc(6);
      chk(duty_now, fosc_pkg::DUTY_FULL);
      rd(fosc_pkg::ADDR_STATUS2);
      chk(d[3], 1'b1);
      ext_pull = 1'b0;
      wr(fosc_pkg::ADDR_FAN_TRAITS, 8'h00);
      rd(fosc_pkg::ADDR_FAN_TRAITS);
      chk(d, 8'h00);
      period = 16'hffff;
      wait_spin(1'b1, 1200);
      period = 16'h1000;
      ext_pull = 1'b1;
      cyc(8);
      chk(duty_now, fosc_pkg::DUTY_FULL);
      ext_pull = 1'b0;
      wait_spin(1'b0, 6000);
      chk(n > 3980 && n < 4000, 1'b1);
      rd(fosc_pkg::ADDR_STATUS1);
      wr(fosc_pkg::ADDR_FAN_TRAITS, 8'h20);
      period = 16'hffff;
      cyc(1200);
      chk(spinning, 1'b0);
      rd(fosc_pkg::ADDR_STATUS1);
      chk(d[1], 1'b1);
      // period set within the deadband of the target
      period = 16'h100a;
      fan_mode_sel = 2'b01;
      wr(fosc_pkg::ADDR_CONFIG_FOUR, 8'h20);
      cyc(12000);
      d0 = duty_now;
      chk(d0 >= fosc_pkg::DUTY_MIN_REG, 1'b1);
      cyc(5200);
      chk(duty_now, d0);
      period = 16'h100b;
      d0 = duty_now;
      for (n = 0; n < 6000 && duty_now === d0; n++) cyc(1);
      chk(duty_now, d0 + 8'h02);
      d0 = duty_now;
      for (n = 0; n < 5200 && duty_now === d0; n++) cyc(1);
      chk(n > 4990 && n < 5010, 1'b1);
      conclude();
   end
   initial begin
      #900000;
      n_errors++;
      conclude();
   end
endmodule
